// ### design/sleep_wake_event_latch.sv
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_event_latch
  import wake_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Core external data-space port
  input  wire logic [15:0] xd_addr,
  input  wire logic        xd_rd,
  input  wire logic        xd_wr,
  input  wire logic [7:0]  xd_wdata,
  output logic      [7:0]  xd_rdata,
  // Falling-edge wake pins
  input  wire logic        falling_input_1,
  input  wire logic        falling_input_2,
  input  wire logic        falling_input_3,
  input  wire logic        falling_input_4,
  input  wire logic        falling_input_5,
  input  wire logic        falling_input_6,
  input  wire logic        general_purpose_wake_input_n,
  input  wire logic        ring_indicator_1_n,
  input  wire logic        ring_indicator_2_n,
  // Either-edge wake pins
  input  wire logic        toggle_input_1,
  input  wire logic        toggle_input_2,
  input  wire logic        toggle_input_3,
  input  wire logic        toggle_input_4,
  // Keyboard scan, shared I/O and infrared receive pins
  input  wire logic [7:0]  keyboard_scan_input,
  input  wire logic        shared_io_pin_eight,
  input  wire logic        infrared_receive_pin,
  // Internal event sources, same clock domain
  input  wire logic        clock_alarm_event,
  input  wire logic        hibernation_countdown_zero,
  input  wire logic        bus_data_activity,
  // Sleep control
  input  wire logic        core_sleep,
  output logic             wake_request,
  output logic             osc_start
);
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic [7:0]       ksi_s;
  logic             any_key_activity;
  logic [7:0]       src1_q;
  logic [7:0]       src2_q;
  logic [SRC3_W-1:0] src3_q;
  logic [7:0]       mask1_q;
  logic [7:0]       mask2_q;
  logic [SRC3_W-1:0] mask3_q;
  logic [7:0]       rdata_q;
  logic [7:0]       rdata_d;
  logic [7:0]       pend1;
  logic [7:0]       pend2;
  logic [SRC3_W-1:0] pend3;
  reg_sel_t         sel;
  logic             rd_src1;
  logic             rd_src2;
  logic             rd_src3;
  logic [EVT_W-1:0] evt;

  wake_event_if #(.W(EVT_W)) ev_if ();

  // Pins gathered for the synchroniser
  assign pin_raw = {infrared_receive_pin, shared_io_pin_eight, keyboard_scan_input,
                    ring_indicator_2_n, ring_indicator_1_n, general_purpose_wake_input_n,
                    toggle_input_4, toggle_input_3, toggle_input_2, toggle_input_1,
                    falling_input_6, falling_input_5, falling_input_4, falling_input_3,
                    falling_input_2, falling_input_1};

  // Every pin passes two flip-flops before any logic looks at it
  wake_sync #(.W(PIN_W)) u_sync (
    .ref_clk  (ref_clk),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  assign ksi_s = pin_s[20:13];

  // Any scan line low means a key is down
  assign any_key_activity = ~(&ksi_s);

  // Levels laid out in source-register bit order
  assign ev_if.level = {
    5'h00,
    pin_s[22],                 // Falling input 8, infrared receive pin
    pin_s[21],                 // Falling input 7, shared I/O pin
    any_key_activity,          // Any-key, rises when a key goes down
    pin_s[12],                 // Ring indicator 2
    pin_s[11],                 // Ring indicator 1
    pin_s[9],                  // Toggle input 4
    pin_s[7],                  // Toggle input 2
    pin_s[8],                  // Toggle input 3
    hibernation_countdown_zero, // Hibernation countdown
    pin_s[5],                  // Falling input 6
    pin_s[10],                 // General purpose wake input
    pin_s[4],                  // Falling input 5
    pin_s[1],                  // Falling input 2
    pin_s[0],                  // Falling input 1
    bus_data_activity,         // Bus data line falls on activity
    pin_s[2],                  // Falling input 3
    pin_s[3],                  // Falling input 4
    pin_s[6],                  // Toggle input 1
    clock_alarm_event          // Alarm match level
  };

  // Edge detection with per-source polarity
  wake_edge #(.W(EVT_W), .RISE(RISE_MASK), .FALL(FALL_MASK)) u_edge (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .ev      (ev_if.det)
  );

  assign evt = ev_if.pulse;

  // Address decode
  always_comb begin
    unique case (xd_addr)
      ADDR_SRC1:  sel = SEL_SRC1;
      ADDR_SRC2:  sel = SEL_SRC2;
      ADDR_SRC3:  sel = SEL_SRC3;
      ADDR_MASK1: sel = SEL_MASK1;
      ADDR_MASK2: sel = SEL_MASK2;
      ADDR_MASK3: sel = SEL_MASK3;
      default:    sel = SEL_NONE;
    endcase
  end

  assign rd_src1 = xd_rd && (sel == SEL_SRC1);
  assign rd_src2 = xd_rd && (sel == SEL_SRC2);
  assign rd_src3 = xd_rd && (sel == SEL_SRC3);

  // Source register one: read clears, a same-cycle edge still sets
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      src1_q <= SRC_RST;
    end else if (rd_src1) begin
      src1_q <= evt[7:0];
    end else begin
      src1_q <= src1_q | evt[7:0];
    end
  end

  // Source register two
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      src2_q <= SRC_RST;
    end else if (rd_src2) begin
      src2_q <= evt[15:8];
    end else begin
      src2_q <= src2_q | evt[15:8];
    end
  end

  // Source register three, only the low three bits exist
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      src3_q <= SRC_RST[SRC3_W-1:0];
    end else if (rd_src3) begin
      src3_q <= evt[16+SRC3_W-1:16];
    end else begin
      src3_q <= src3_q | evt[16+SRC3_W-1:16];
    end
  end

  // Mask registers, a 1 masks
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mask1_q <= MASK12_RST;
      mask2_q <= MASK12_RST;
      mask3_q <= MASK3_RST[SRC3_W-1:0];
    end else if (xd_wr) begin
      if (sel == SEL_MASK1) begin
        mask1_q <= xd_wdata;
      end
      if (sel == SEL_MASK2) begin
        mask2_q <= xd_wdata;
      end
      if (sel == SEL_MASK3) begin
        mask3_q <= xd_wdata[SRC3_W-1:0];
      end
    end
  end

  // Read mux; reserved bits of mask three read one, of source three zero
  always_comb begin
    unique case (sel)
      SEL_SRC1:  rdata_d = src1_q;
      SEL_SRC2:  rdata_d = src2_q;
      SEL_SRC3:  rdata_d = {SRC3_RSVD, src3_q};
      SEL_MASK1: rdata_d = mask1_q;
      SEL_MASK2: rdata_d = mask2_q;
      SEL_MASK3: rdata_d = {MASK3_RST[7:SRC3_W], mask3_q};
      default:   rdata_d = 8'h00;
    endcase
  end

  // Read data held until the next read; it shows the value before clearing
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (xd_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign xd_rdata = rdata_q;

  // Unmasked pending events
  assign pend1 = src1_q & ~mask1_q;
  assign pend2 = src2_q & ~mask2_q;
  assign pend3 = src3_q & ~mask3_q;

  // Straight from the latches, so it needs no clock to reach the oscillator
  assign wake_request = (|pend1) | (|pend2) | (|pend3);

  // Oscillator start while asleep; the core resumes once the clock is stable
  assign osc_start = core_sleep & wake_request;

  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence rd1_quiet;
    rd_src1 && (evt[7:0] == 8'h00);
  endsequence

  sequence alarm_rise;
    ev_if.primed && clock_alarm_event && !$past(clock_alarm_event);
  endsequence

  sequence alarm_held_read;
    rd_src1 && clock_alarm_event && $past(clock_alarm_event);
  endsequence

  sequence bus_fall;
    ev_if.primed && !bus_data_activity && $past(bus_data_activity);
  endsequence

  sequence shared_fall;
    ev_if.primed && !pin_s[21] && $past(pin_s[21]);
  endsequence

  src_clear_a: assert property (rd1_quiet |=> src1_q == 8'h00)
    else $error("source one not cleared by read");

  src_readback_a: assert property (rd_src1 |=> xd_rdata == $past(src1_q))
    else $error("source one read returned wrong value");

  // A read straight after the set may clear it, so the second cycle allows for that
  alarm_set_a: assert property (
    alarm_rise |=> src1_q[B_ALARM] ##1 (src1_q[B_ALARM] || $past(rd_src1)))
    else $error("alarm edge not latched");

  alarm_no_relatch_a: assert property (
    alarm_held_read ##1 clock_alarm_event |-> !src1_q[B_ALARM])
    else $error("alarm bit relatched from level");

  toggle_either_a: assert property (
    ev_if.primed && !rd_src1 && $changed(pin_s[6]) |=> src1_q[B_TOG1])
    else $error("toggle input edge not latched");

  hib_set_a: assert property (
    ev_if.primed && !rd_src2 && $rose(hibernation_countdown_zero)
    |=> src2_q[B_HIB - 8])
    else $error("hibernation event not latched");

  anykey_set_a: assert property (
    ev_if.primed && !rd_src3 && $fell(&ksi_s) |=> src3_q[B_ANYKEY - 16])
    else $error("any-key event not latched");

  ir_fall_a: assert property (
    ev_if.primed && !rd_src3 && $fell(pin_s[22]) |=> src3_q[B_INFRARED_RECEIVE_PIN - 16])
    else $error("infrared edge not latched");

  mask_write_a: assert property (
    xd_wr && sel == SEL_MASK1 |=> mask1_q == $past(xd_wdata))
    else $error("mask one write lost");

  mask3_reset_a: assert property (
    $past(!resetn) |-> mask3_q == MASK3_RST[SRC3_W-1:0])
    else $error("mask three reset value wrong");

  wake_req_a: assert property (
    src1_q[B_BUS] && !mask1_q[B_BUS] |-> wake_request && (!core_sleep || osc_start))
    else $error("unmasked event gave no wake request");

  osc_hold_a: assert property (
    core_sleep && wake_request && !xd_rd && !xd_wr |=> osc_start || !core_sleep)
    else $error("oscillator request dropped while asleep");

  // Read clears, but an edge landing in the read cycle survives
  src1_set_wins_a: assert property (rd_src1 |=> src1_q == $past(evt[7:0]))
    else $error("source one read clear wrong");

  src2_clear_a: assert property (rd_src2 |=> src2_q == $past(evt[15:8]))
    else $error("source two read clear wrong");

  src3_clear_a: assert property (
    rd_src3 |=> src3_q == $past(evt[16+SRC3_W-1:16]))
    else $error("source three read clear wrong");

  // Latched bits only ever go away through a read or a reset
  src1_sticky_a: assert property (
    !rd_src1 |=> (src1_q & $past(src1_q)) == $past(src1_q))
    else $error("source one bit lost without read");

  src2_sticky_a: assert property (
    !rd_src2 |=> (src2_q & $past(src2_q)) == $past(src2_q))
    else $error("source two bit lost without read");

  src3_sticky_a: assert property (
    !rd_src3 |=> (src3_q & $past(src3_q)) == $past(src3_q))
    else $error("source three bit lost without read");

  // Read data of source two, source three and mask three, reserved bits included
  src2_readback_a: assert property (rd_src2 |=> xd_rdata == $past(src2_q))
    else $error("source two read returned wrong value");

  src3_readback_a: assert property (
    rd_src3 |=> xd_rdata == {SRC3_RSVD, $past(src3_q)})
    else $error("source three read returned wrong value");

  mask3_read_a: assert property (
    xd_rd && sel == SEL_MASK3 |=> xd_rdata == {MASK3_RST[7:SRC3_W], $past(mask3_q)})
    else $error("mask three read returned wrong value");

  mask2_write_a: assert property (
    xd_wr && sel == SEL_MASK2 |=> mask2_q == $past(xd_wdata))
    else $error("mask two write lost");

  bus_set_a: assert property (bus_fall |=> src1_q[B_BUS])
    else $error("bus activity not latched");

  shared_fall_a: assert property (shared_fall |=> src3_q[B_IRSHR - 16])
    else $error("shared pin edge not latched");
endmodule
`default_nettype wire

// ### design/wake_pkg.sv
package wake_pkg;
  // Core data-space register addresses
  localparam logic [15:0] ADDR_SRC1  = 16'h7F2A;
  localparam logic [15:0] ADDR_SRC2  = 16'h7F2B;
  localparam logic [15:0] ADDR_MASK1 = 16'h7F2C;
  localparam logic [15:0] ADDR_MASK2 = 16'h7F2D;
  localparam logic [15:0] ADDR_SRC3  = 16'h7F35;
  localparam logic [15:0] ADDR_MASK3 = 16'h7F36;
  // Reset values
  localparam logic [7:0]  SRC_RST    = 8'h00;
  localparam logic [7:0]  MASK12_RST = 8'h00;
  localparam logic [7:0]  MASK3_RST  = 8'hFF;
  localparam logic [4:0]  SRC3_RSVD  = 5'h00;
  // Event vector: the three source registers side by side, bit 8*r+b
  localparam int          EVT_W      = 24;
  localparam int          SRC3_W     = 3;
  localparam int          PIN_W      = 23;
  localparam logic [23:0] RISE_MASK  = 24'h013C03;
  localparam logic [23:0] FALL_MASK  = 24'h06FBFE;
  // Bit positions within the event vector
  localparam int B_ALARM  = 0;
  localparam int B_TOG1   = 1;
  localparam int B_BUS    = 4;
  localparam int B_HIB    = 10;
  localparam int B_ANYKEY = 16;
  localparam int B_IRSHR  = 17;
  localparam int B_INFRARED_RECEIVE_PIN   = 18;
  // Register select codes
  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_SRC1  = 3'b001,
    SEL_SRC2  = 3'b010,
    SEL_SRC3  = 3'b011,
    SEL_MASK1 = 3'b100,
    SEL_MASK2 = 3'b101,
    SEL_MASK3 = 3'b110
  } reg_sel_t;
endpackage

// ### design/wake_event_if.sv
`timescale 1ns/100ps
`default_nettype none
interface wake_event_if #(parameter int W = 24);
  logic [W-1:0] level;
  logic [W-1:0] pulse;
  logic         primed;
  // Detector samples levels and returns one-cycle edge pulses
  modport det (input level, output pulse, output primed);
  modport usr (output level, input pulse, input primed);
endinterface
`default_nettype wire

// ### design/wake_sync.sv
`timescale 1ns/100ps
`default_nettype none
module wake_sync #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         ref_clk,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // No reset: the chain must already hold true pin levels when reset lifts
  always_ff @(posedge ref_clk) begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### design/wake_edge.sv
`timescale 1ns/100ps
`default_nettype none
module wake_edge #(
  parameter int           W    = 24,
  parameter logic [W-1:0] RISE = '0,
  parameter logic [W-1:0] FALL = '0
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Levels in, edge pulses out
  wake_event_if.det ev
);
  logic [W-1:0] prev_q;
  logic         primed_q;

  // Previous level, unreset so the first compare is against a real level
  always_ff @(posedge ref_clk) begin
    prev_q <= ev.level;
  end

  // One blind cycle after reset avoids a false edge from stale history
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  // Per-bit edge sensitivity
  assign ev.pulse  = {W{primed_q}} & ((RISE & ev.level & ~prev_q) | (FALL & ~ev.level & prev_q));
  assign ev.primed = primed_q;
endmodule
`default_nettype wire

// ### verif/wake_far_side.sv
`timescale 1ns/100ps
`default_nettype none
// Far side of the block: wake pins and internal event levels
module wake_far_side (
  // One level per event bit, set by the bench
  input  wire logic [23:0] lvl,
  // Source register one events
  output logic             clock_alarm_event,
  output logic             toggle_input_1,
  output logic             falling_input_4,
  output logic             falling_input_3,
  output logic             bus_data_activity,
  output logic             falling_input_1,
  output logic             falling_input_2,
  output logic             falling_input_5,
  // Source register two events
  output logic             general_purpose_wake_input_n,
  output logic             falling_input_6,
  output logic             hibernation_countdown_zero,
  output logic             toggle_input_3,
  output logic             toggle_input_2,
  output logic             toggle_input_4,
  output logic             ring_indicator_1_n,
  output logic             ring_indicator_2_n,
  // Source register three events
  output logic      [7:0]  keyboard_scan_input,
  output logic             shared_io_pin_eight,
  output logic             infrared_receive_pin
);
  // Bit index equals register bit, so one vector drives every source
  assign clock_alarm_event = lvl[0];
  assign toggle_input_1 = lvl[1];
  assign falling_input_4 = lvl[2];
  assign falling_input_3 = lvl[3];
  assign bus_data_activity = lvl[4];
  assign falling_input_1 = lvl[5];
  assign falling_input_2 = lvl[6];
  assign falling_input_5 = lvl[7];
  assign general_purpose_wake_input_n = lvl[8];
  assign falling_input_6 = lvl[9];
  assign hibernation_countdown_zero = lvl[10];
  assign toggle_input_3 = lvl[11];
  assign toggle_input_2 = lvl[12];
  assign toggle_input_4 = lvl[13];
  assign ring_indicator_1_n = lvl[14];
  assign ring_indicator_2_n = lvl[15];
  // Only scan line 7 moves; the others stay released high
  assign keyboard_scan_input = {lvl[16], 7'h7F};
  assign shared_io_pin_eight = lvl[17];
  assign infrared_receive_pin = lvl[18];
endmodule
`default_nettype wire

// ### verif/sleep_wake_event_latch_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_event_latch_tb_top;
  import wake_pkg::*;
  // Idle levels: falling sources and scan line 7 high, other rising and toggle sources low
  localparam logic [23:0] IDLE = 24'h07C3FC;
  localparam logic [23:0] TOG  = 24'h003802;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] xd_addr = 16'h0000;
  logic        xd_rd = 1'b0;
  logic        xd_wr = 1'b0;
  logic [7:0]  xd_wdata = 8'h00;
  logic [7:0]  xd_rdata;
  logic        core_sleep = 1'b0;
  logic        wake_request;
  logic        osc_start;
  logic [23:0] lvl = IDLE;
  logic [7:0]  keyboard_scan_input;
  logic        clock_alarm_event, toggle_input_1, falling_input_4, falling_input_3,
               bus_data_activity, falling_input_1, falling_input_2, falling_input_5,
               general_purpose_wake_input_n, falling_input_6, hibernation_countdown_zero,
               toggle_input_3, toggle_input_2, toggle_input_4, ring_indicator_1_n,
               ring_indicator_2_n, shared_io_pin_eight, infrared_receive_pin;
  int          err_total = 0;
  int          checked = 0;

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  wake_far_side far (.*);
  sleep_wake_event_latch uut (.*);

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    xd_addr = a;
    xd_wdata = d;
    xd_wr = 1'b1;
    @(negedge ref_clk);
    xd_wr = 1'b0;
  endtask

  // Read data is sampled a full cycle after the strobe edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    xd_addr = a;
    xd_rd = 1'b1;
    @(negedge ref_clk);
    xd_rd = 1'b0;
    @(negedge ref_clk);
    check(xd_rdata, exp);
  endtask

  // Flip one source; synchroniser plus latch need about three cycles
  task automatic edge_at(input int i);
    @(negedge ref_clk);
    lvl[i] = ~lvl[i];
    repeat (5) @(negedge ref_clk);
  endtask

  // Hang guard
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end

  initial begin
    logic [15:0] a;
    logic [7:0]  b;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
    // Reset values
    check({7'h00, wake_request}, 8'h00);
    rd(ADDR_SRC1, 8'h00);
    rd(ADDR_SRC2, 8'h00);
    rd(ADDR_SRC3, 8'h00);
    rd(ADDR_MASK1, 8'h00);
    rd(ADDR_MASK2, 8'h00);
    rd(ADDR_MASK3, 8'hFF);
    // Any-key starts masked: latched, yet no wake
    core_sleep = 1'b1;
    edge_at(16);
    check({6'h00, osc_start, wake_request}, 8'h00);
    rd(ADDR_SRC3, 8'h01);
    edge_at(16);
    // Mask read-back; reserved mask bits always read one
    wr(ADDR_MASK1, 8'hA5);
    rd(ADDR_MASK1, 8'hA5);
    wr(ADDR_MASK2, 8'h5A);
    rd(ADDR_MASK2, 8'h5A);
    wr(ADDR_MASK3, 8'h02);
    rd(ADDR_MASK3, 8'hFA);
    // Source registers are read-only, unmapped reads give zero
    wr(ADDR_SRC1, 8'hFF);
    rd(ADDR_SRC1, 8'h00);
    rd(16'h7F2E, 8'h00);
    // Masked shared pin still latches
    edge_at(17);
    check({7'h00, wake_request}, 8'h00);
    rd(ADDR_SRC3, 8'h02);
    edge_at(17);
    wr(ADDR_MASK1, 8'h00);
    wr(ADDR_MASK2, 8'h00);
    wr(ADDR_MASK3, 8'h00);
    // Every source in turn: position, wake, clear on read, return edge
    for (int i = 0; i < 19; i++) begin
      a = (i < 8) ? ADDR_SRC1 : (i < 16) ? ADDR_SRC2 : ADDR_SRC3;
      b = 8'(1 << (i % 8));
      edge_at(i);
      check({6'h00, osc_start, wake_request}, 8'h03);
      rd(a, b);
      rd(a, 8'h00);
      check({7'h00, wake_request}, 8'h00);
      edge_at(i);
      rd(a, TOG[i] ? b : 8'h00);
    end
    // Awake core: masked gives nothing, unmasked wakes without the oscillator
    core_sleep = 1'b0;
    wr(ADDR_MASK1, 8'h20);
    edge_at(5);
    check({6'h00, osc_start, wake_request}, 8'h00);
    wr(ADDR_MASK1, 8'h00);
    check({6'h00, osc_start, wake_request}, 8'h01);
    rd(ADDR_SRC1, 8'h20);
    // Mask two holds off a latched source, then a mid-run reset
    wr(ADDR_MASK2, 8'hC3);
    edge_at(9);
    check({7'h00, wake_request}, 8'h00);
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    check({7'h00, wake_request}, 8'h00);
    rd(ADDR_SRC2, 8'h00);
    rd(ADDR_MASK2, 8'h00);
    rd(ADDR_MASK3, 8'hFF);
    // Rising edges on falling-edge pins latch nothing
    edge_at(5);
    edge_at(9);
    rd(ADDR_SRC1, 8'h00);
    rd(ADDR_SRC2, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
